// file: hw/mrr_cfg.svh
// Offsets, field positions, reset values and scaling for the result bank
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH

// Register indices, byte address is four times the index
`define MRR_IDX_CELL 8'h54
`define MRR_IDX_STACK 8'h55
`define MRR_IDX_SUM 8'h56
`define MRR_IDX_DIAGNOSTIC_CODE_FIRST 8'h57
`define MRR_IDX_DIAGNOSTIC_CODE_SECOND 8'h58
`define MRR_IDX_CTRL 8'h70
`define MRR_IDX_STAT 8'h71

// Field positions
`define MRR_CODE_LSB 2
`define MRR_FILT_SEL_BIT 0
`define MRR_STAT_LOADED_LSB 0
`define MRR_STAT_SEL1_LSB 8
`define MRR_STAT_SEL2_LSB 12
`define MRR_STAT_COUNT_LSB 16

// Reset values
`define MRR_CODE_RST 14'h0000
`define MRR_SUM_RST 16'h0000
`define MRR_CTRL_RST 1'h0

// Scaling: full-scale ranges in millivolts, sum LSB in microvolts
`define MRR_CELL_FS_MV 5000
`define MRR_STACK_FS_MV 65000
`define MRR_SUM_FS_MV 80000
`define MRR_SUM_LSB_UV 1220
// Cell LSB 5 V / 2^14 is a quarter of the sum LSB 80 V / 2^16
`define MRR_SUM_SHIFT 2

`endif

// file: hw/mrr_pkg.sv
// Types shared by the measurement result bank
`default_nettype none
package mrr_pkg;

    // APB request from the master
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mrr_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mrr_apb_rsp_t;

    // Results offered by the scan engine at the end of a scan
    typedef struct packed {
        logic done;
        logic cell_measured;
        logic cell_measure_enable;
        logic [13:0] last_cell_code;
        logic [13:0] last_cell_filt;
        logic stack_measured;
        logic stack_measure_enable;
        logic [13:0] stack_voltage_code;
        logic [13:0] stack_voltage_filt;
        logic [3:0] diagnostic_selector_first;
        logic [3:0] diagnostic_selector_second;
        logic [13:0] diagnostic_code_first;
        logic [13:0] diagnostic_code_second;
    } mrr_scan_t;

endpackage : mrr_pkg
`default_nettype wire

// file: hw/mrr_sum.sv
// Signed sum of enabled cell results, scaled and clipped to 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "mrr_cfg.svh"
module mrr_sum #(
    parameter int NCH = 14,
    parameter int CW = 14
) (
    input wire logic [NCH*CW-1:0] codes_i,
    input wire logic [NCH-1:0] enable_i,
    input wire logic [NCH-1:0] bipolar_i,
    output logic [15:0] sum_o
);
    localparam int SW = CW + $clog2(NCH) + 2;

    logic signed [SW-1:0] term [NCH];
    logic signed [SW-1:0] acc;
    logic signed [SW-1:0] scaled;

    ////////////////////////////////////////////////////////////////////
    // Per-channel term in its own encoding, zero when not enabled
    for (genvar g = 0; g < NCH; g++) begin : g_term
        logic [CW-1:0] c;
        assign c = codes_i[g*CW +: CW];
        always_comb begin
            if (!enable_i[g]) begin // RULE_07
                term[g] = '0; // RULE_09
            end else if (bipolar_i[g]) begin
                term[g] = SW'(signed'(c)); // RULE_10
            end else begin
                term[g] = SW'($unsigned(c)); // RULE_10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulate, rescale to the sum LSB, clip at both ends
    always_comb begin
        acc = '0;
        for (int i = 0; i < NCH; i++) begin
            acc = acc + term[i];
        end
        scaled = acc >>> `MRR_SUM_SHIFT; // RULE_08
        if (scaled < 0) begin
            sum_o = `MRR_SUM_RST; // RULE_11
        end else if (scaled > SW'(17'sh0ffff)) begin
            sum_o = 16'hffff;
        end else begin
            sum_o = scaled[15:0]; // RULE_07
        end
    end

endmodule : mrr_sum
`default_nettype wire

// file: hw/mrr_regs.sv
// Measurement result register bank with APB slave
// What this block does
// RULE_01: Last cell code sits in bits 15:2
// RULE_02: Cell code spans 5 V full scale
// RULE_03: Skipped disabled cell keeps data; readback per select
// RULE_04: Stack code sits in bits 15:2
// RULE_05: Stack code spans 65 V full scale
// RULE_06: Skipped disabled stack keeps data; readback per select
// RULE_07: 16-bit sum of cells enabled this scan
// RULE_08: Sum unsigned 0 to 80 V, 1.22 mV LSB
// RULE_09: Disabled channels hold results, excluded from sum
// RULE_10: Sum each term in its own encoding
// RULE_11: Negative sum clips to zero
// RULE_12: First diagnostic code in bits 15:2
// RULE_13: Second diagnostic code in bits 15:2
// RULE_14: Writes to results ignored; low bits read zero
// RULE_15: All results load together at scan end
`timescale 1ns/1ps
`default_nettype none
`include "mrr_cfg.svh"
module mrr_regs #(
    parameter int NCH = 14,
    parameter int CW = 14
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire mrr_pkg::mrr_apb_req_t apb_i,
    output mrr_pkg::mrr_apb_rsp_t apb_o,
    input wire mrr_pkg::mrr_scan_t scan_i,
    input wire logic [NCH*CW-1:0] cell_codes_i,
    input wire logic [NCH-1:0] measure_enable_set_one_i,
    input wire logic [NCH-1:0] bipolar_i,
    output logic filtered_readback_select_o
);

    ////////////////////////////////////////////////////////////////////
    // Word map, byte address is four times the index
    //   0x54 last cell code, raw or filtered, bits 15:2
    //   0x55 stack code, raw or filtered, bits 15:2
    //   0x56 sum of enabled cells, bits 15:0
    //   0x57 first diagnostic code, bits 15:2
    //   0x58 second diagnostic code, bits 15:2
    //   0x70 control, bit 0 filtered readback select
    //   0x71 status, loaded flags, selectors, scan count
    // Status bits 31:24 read zero
    // Unaligned or unlisted addresses answer with an error
    // Result words never take writes; only control does

    // Address decode shared by reads and writes
    function automatic logic reg_hit(input logic [11:0] a,
                                     input logic [7:0] idx);
        reg_hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
    endfunction : reg_hit

    // Place a 14-bit code at its field, low bits zero
    function automatic logic [31:0] code_word(input logic [13:0] c);
        code_word = 32'h0; // RULE_14
        code_word[`MRR_CODE_LSB +: 14] = c;
    endfunction : code_word

    ////////////////////////////////////////////////////////////////////
    // Result state
    logic [13:0] cell_raw_q;
    logic [13:0] cell_raw_d;
    logic [13:0] cell_filt_q;
    logic [13:0] cell_filt_d;

    // Stack voltage, raw and filtered
    logic [13:0] stack_raw_q;
    logic [13:0] stack_raw_d;
    logic [13:0] stack_filt_q;
    logic [13:0] stack_filt_d;

    // Clipped sum of the enabled cells
    logic [15:0] sum_q;
    logic [15:0] sum_d;

    // Diagnostic codes and their selectors
    logic [13:0] diagnostic_code_first_q;
    logic [13:0] diagnostic_code_first_d;
    logic [13:0] diagnostic_code_second_q;
    logic [13:0] diagnostic_code_second_d;
    logic [3:0] sel1_q;
    logic [3:0] sel1_d;
    logic [3:0] sel2_q;
    logic [3:0] sel2_d;

    // Status: loaded flags and scan count
    logic [4:0] loaded_q;
    logic [4:0] loaded_d;
    logic [7:0] scan_cnt_q;
    logic [7:0] scan_cnt_d;

    // Sum of this scan and update gates
    logic [15:0] sum_now;
    logic cell_upd;
    logic stack_upd;

    // Control and bus state
    logic filt_sel_q;
    logic filt_sel_d;

    // Registered answer to the master
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    // Phase and decode of the current request
    logic setup;
    logic commit;
    logic mapped;
    logic writable;

    ////////////////////////////////////////////////////////////////////
    // Sum of the cell results of the current scan
    // Inputs are sampled only at scan done, so the sum
    // and the results it describes come from one scan
    mrr_sum #(
        .NCH(NCH),
        .CW(CW)
    ) u_sum (
        .codes_i(cell_codes_i),
        .enable_i(measure_enable_set_one_i),
        .bipolar_i(bipolar_i),
        .sum_o(sum_now)
    );

    ////////////////////////////////////////////////////////////////////
    // Skipped channels with their enable cleared are not refreshed
    // Measured or enabled means this scan produced a value
    always_comb begin
        cell_upd = scan_i.cell_measure_enable
                   || scan_i.cell_measured; // RULE_03
        stack_upd = scan_i.stack_measure_enable
                    || scan_i.stack_measured; // RULE_06
    end

    // Next result values, all taken on the same scan-done edge
    always_comb begin
        cell_raw_d = cell_raw_q;
        cell_filt_d = cell_filt_q;
        stack_raw_d = stack_raw_q;
        stack_filt_d = stack_filt_q;
        sum_d = sum_q;
        diagnostic_code_first_d = diagnostic_code_first_q;
        diagnostic_code_second_d = diagnostic_code_second_q;
        sel1_d = sel1_q;
        sel2_d = sel2_q;
        loaded_d = loaded_q;
        scan_cnt_d = scan_cnt_q;
        if (scan_i.done) begin // RULE_15
            // Last cell, kept when skipped and disabled
            if (cell_upd) begin
                cell_raw_d = scan_i.last_cell_code; // RULE_02
                cell_filt_d = scan_i.last_cell_filt;
                loaded_d[0] = 1'b1;
            end
            // Stack voltage, same skip rule
            if (stack_upd) begin
                stack_raw_d = scan_i.stack_voltage_code; // RULE_05
                stack_filt_d = scan_i.stack_voltage_filt;
                loaded_d[1] = 1'b1;
            end
            // Sum always reflects this scan's enables
            sum_d = sum_now; // RULE_07
            loaded_d[2] = 1'b1;
            // Diagnostics with the selectors that chose them
            diagnostic_code_first_d = scan_i.diagnostic_code_first; // RULE_12
            sel1_d = scan_i.diagnostic_selector_first;
            loaded_d[3] = 1'b1;
            diagnostic_code_second_d = scan_i.diagnostic_code_second; // RULE_13
            sel2_d = scan_i.diagnostic_selector_second;
            loaded_d[4] = 1'b1;
            // Scan count wraps
            scan_cnt_d = scan_cnt_q + 8'h01;
        end
    end

    // Result registers
    // Reset clears every code, the sum and the status
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cell_raw_q <= `MRR_CODE_RST;
            cell_filt_q <= `MRR_CODE_RST;
            stack_raw_q <= `MRR_CODE_RST;
            stack_filt_q <= `MRR_CODE_RST;
            sum_q <= `MRR_SUM_RST;
            diagnostic_code_first_q <= `MRR_CODE_RST;
            diagnostic_code_second_q <= `MRR_CODE_RST;
            sel1_q <= 4'h0;
            sel2_q <= 4'h0;
            loaded_q <= 5'h00;
            scan_cnt_q <= 8'h00;
        end else begin
            cell_raw_q <= cell_raw_d;
            cell_filt_q <= cell_filt_d;
            stack_raw_q <= stack_raw_d;
            stack_filt_q <= stack_filt_d;
            sum_q <= sum_d;
            diagnostic_code_first_q <= diagnostic_code_first_d;
            diagnostic_code_second_q <= diagnostic_code_second_d;
            sel1_q <= sel1_d;
            sel2_q <= sel2_d;
            loaded_q <= loaded_d;
            scan_cnt_q <= scan_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB phase tracking and decode
    // No wait states: ready follows setup by one cycle
    // Commit needs ready so a stray enable writes nothing
    // Address must be word aligned to hit a register
    always_comb begin
        setup = apb_i.psel && !apb_i.penable;
        commit = apb_i.psel && apb_i.penable && pready_q;
        mapped = reg_hit(apb_i.paddr, `MRR_IDX_CELL)
                 || reg_hit(apb_i.paddr, `MRR_IDX_STACK)
                 || reg_hit(apb_i.paddr, `MRR_IDX_SUM)
                 || reg_hit(apb_i.paddr, `MRR_IDX_DIAGNOSTIC_CODE_FIRST)
                 || reg_hit(apb_i.paddr, `MRR_IDX_DIAGNOSTIC_CODE_SECOND)
                 || reg_hit(apb_i.paddr, `MRR_IDX_CTRL)
                 || reg_hit(apb_i.paddr, `MRR_IDX_STAT);
        writable = reg_hit(apb_i.paddr, `MRR_IDX_CTRL); // RULE_14
    end

    // Control register, only written at the completing edge
    // Result and status words have no write path
    always_comb begin
        filt_sel_d = filt_sel_q;
        if (commit && apb_i.pwrite && writable) begin
            filt_sel_d = apb_i.pwdata[`MRR_FILT_SEL_BIT];
        end
    end

    // Answer prepared in setup, shown for the single access cycle
    // Data is zero outside reads so idle cycles stay quiet
    always_comb begin
        prdata_d = 32'h0;
        pready_d = setup;
        pslverr_d = 1'b0;
        // Error answer for unmapped or unaligned words
        if (setup) begin
            pslverr_d = !mapped;
            // Writes return zero data
            if (!apb_i.pwrite) begin
                if (reg_hit(apb_i.paddr, `MRR_IDX_CELL)) begin
                    prdata_d = code_word(filt_sel_q ? cell_filt_q
                                         : cell_raw_q); // RULE_01
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_STACK)) begin
                    prdata_d = code_word(filt_sel_q ? stack_filt_q
                                         : stack_raw_q); // RULE_04
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_SUM)) begin
                    prdata_d = {16'h0, sum_q};
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_DIAGNOSTIC_CODE_FIRST)) begin
                    prdata_d = code_word(diagnostic_code_first_q); // RULE_12
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_DIAGNOSTIC_CODE_SECOND)) begin
                    prdata_d = code_word(diagnostic_code_second_q); // RULE_13
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_CTRL)) begin
                    prdata_d[`MRR_FILT_SEL_BIT] = filt_sel_q;
                end else if (reg_hit(apb_i.paddr, `MRR_IDX_STAT)) begin
                    // Flags, selectors and count side by side
                    prdata_d[`MRR_STAT_LOADED_LSB +: 5] = loaded_q;
                    prdata_d[`MRR_STAT_SEL1_LSB +: 4] = sel1_q;
                    prdata_d[`MRR_STAT_SEL2_LSB +: 4] = sel2_q;
                    prdata_d[`MRR_STAT_COUNT_LSB +: 8] = scan_cnt_q;
                end else begin
                    prdata_d = 32'h0;
                end
            end
        end
    end

    // Bus and control registers
    // Ready and error drop back to zero after one cycle
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_sel_q <= `MRR_CTRL_RST;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            filt_sel_q <= filt_sel_d; // RULE_14
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // Keeps the bus answer free of decode glitches
    always_comb begin
        apb_o.prdata = prdata_q;
        apb_o.pready = pready_q;
        apb_o.pslverr = pslverr_q;
        filtered_readback_select_o = filt_sel_q; // RULE_03
    end

endmodule : mrr_regs
`default_nettype wire

// file: verif/mrr_regs_checker.sv
// Port assertions for the result bank
`timescale 1ns/1ps
`default_nettype none
module mrr_regs_checker (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire mrr_pkg::mrr_apb_req_t apb_i,
    input wire mrr_pkg::mrr_apb_rsp_t apb_o,
    input wire logic filtered_readback_select_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Request decodes
    logic ctrl_wr;
    logic code_rd;
    assign ctrl_wr = apb_i.psel && apb_i.penable && apb_o.pready
        && apb_i.pwrite && apb_i.paddr == 12'h1c0;
    assign code_rd = !apb_i.pwrite && (apb_i.paddr == 12'h150
        || apb_i.paddr == 12'h154 || apb_i.paddr == 12'h15c
        || apb_i.paddr == 12'h160);
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_result_setup;
        s_setup ##0 (apb_i.paddr >= 12'h150 && apb_i.paddr <= 12'h160
            && apb_i.paddr[1:0] == 2'h0);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> apb_o.pready)
        else $error("ready missing after setup");
    a_ready_one_pulse: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("ready longer than one cycle");
    a_idle_bus_quiet: assert property (!apb_o.pready |->
        apb_o.prdata == 32'h0 && !apb_o.pslverr)
        else $error("read data or error outside access");
    a_result_write_ok: assert property (
        s_result_setup |=> !apb_o.pslverr)
        else $error("error on result register access");
    a_code_field_place: assert property (
        apb_o.pready && code_rd |->
        apb_o.prdata[1:0] == 2'h0 && apb_o.prdata[31:16] == 16'h0)
        else $error("code outside bits 15 to 2");
    a_sum_field_width: assert property (
        apb_o.pready && !apb_i.pwrite && apb_i.paddr == 12'h158 |->
        apb_o.prdata[31:16] == 16'h0)
        else $error("sum wider than 16 bits");
    a_select_takes_write: assert property (ctrl_wr |=>
        filtered_readback_select_o == $past(apb_i.pwdata[0]))
        else $error("readback select missed write");
    a_select_holds: assert property (!ctrl_wr |=>
        $stable(filtered_readback_select_o))
        else $error("readback select changed alone");
endmodule : mrr_regs_checker
bind mrr_regs mrr_regs_checker u_chk (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .apb_i(apb_i),
    .apb_o(apb_o),
    .filtered_readback_select_o(filtered_readback_select_o)
);
`default_nettype wire

// file: verif/mrr_regs_tb_top.sv
// Self-checking bench for the result bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module mrr_regs_tb_top;
    logic sys_clk_i;
    logic sys_rst_i;
    mrr_pkg::mrr_apb_req_t rq;
    mrr_pkg::mrr_apb_rsp_t rs;
    mrr_pkg::mrr_scan_t sc;
    logic [195:0] cc;
    logic [13:0] en;
    logic [13:0] bip;
    logic sel;
    logic [31:0] rd;
    logic er;
    int n_errors;
    int tests_run;
    mrr_regs DUT (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .apb_i(rq),
        .apb_o(rs),
        .scan_i(sc),
        .cell_codes_i(cc),
        .measure_enable_set_one_i(en),
        .bipolar_i(bip),
        .filtered_readback_select_o(sel)
    );
    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // One APB transfer, request held until ready
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        rq.paddr <= a;
        rq.pwrite <= w;
        rq.pwdata <= d;
        rq.psel <= 1'b1;
        rq.penable <= 1'b0;
        @(posedge sys_clk_i);
        rq.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (rs.pready !== 1'b1);
        rd = rs.prdata;
        er = rs.pslverr;
    endtask : xfer
    // Bus release
    task automatic idle();
        rq.psel <= 1'b0;
        rq.penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask : idle
    // Read and compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input logic ee);
        xfer(a, 1'b0, 32'h0);
        `CHK("prdata", e, rd)
        `CHK("pslverr", ee, er)
    endtask : rchk
    // End of scan strobe
    task automatic pulse();
        idle();
        sc.done <= 1'b1;
        @(posedge sys_clk_i);
        sc.done <= 1'b0;
    endtask : pulse
    // Code placed in bits 15:2
    function automatic logic [31:0] fc(input logic [13:0] x);
        return {16'h0000, x, 2'h0};
    endfunction : fc
    // Sum of enabled terms, quarter scale, clipped
    function automatic logic [31:0] es();
        int a;
        a = 0;
        for (int g = 0; g < 14; g++) begin
            if (en[g]) begin
                a += bip[g] ? int'($signed(cc[g*14+:14]))
                    : int'(cc[g*14+:14]);
            end
        end
        a = a >>> 2;
        a = (a < 0) ? 0 : ((a > 65535) ? 65535 : a);
        return {16'h0000, a[15:0]};
    endfunction : es
    // Verdict
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Watchdog
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        n_errors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        rq = '0;
        sc = '0;
        cc = '0;
        en = '0;
        bip = '0;
        sys_rst_i = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        for (int i = 0; i < 5; i++) begin
            rchk(12'h150 + 12'(4 * i), 32'h0, 1'b0);
        end
        // Full scale scan, all channels enabled
        sc.cell_measured <= 1'b1;
        sc.cell_measure_enable <= 1'b1;
        sc.last_cell_code <= 14'h3fff;
        sc.last_cell_filt <= 14'h0155;
        sc.stack_measured <= 1'b1;
        sc.stack_measure_enable <= 1'b1;
        sc.stack_voltage_code <= 14'h2abc;
        sc.stack_voltage_filt <= 14'h0aa0;
        sc.diagnostic_selector_first <= 4'h3;
        sc.diagnostic_selector_second <= 4'hc;
        sc.diagnostic_code_first <= 14'h1234;
        sc.diagnostic_code_second <= 14'h0fed;
        cc <= {14{14'h3fff}};
        en <= 14'h3fff;
        pulse();
        rchk(12'h150, fc(14'h3fff), 1'b0);
        rchk(12'h154, fc(14'h2abc), 1'b0);
        rchk(12'h158, es(), 1'b0);
        rchk(12'h15c, fc(14'h1234), 1'b0);
        rchk(12'h160, fc(14'h0fed), 1'b0);
        // Writes to results are dropped
        for (int i = 0; i < 5; i++) begin
            xfer(12'h150 + 12'(4 * i), 1'b1, 32'hffffffff);
            `CHK("wr err", 1'b0, er)
        end
        rchk(12'h150, fc(14'h3fff), 1'b0);
        rchk(12'h158, 32'h0000dffc, 1'b0);
        // Filtered readback
        xfer(12'h1c0, 1'b1, 32'h1);
        rchk(12'h1c0, 32'h00000001, 1'b0);
        rchk(12'h150, fc(14'h0155), 1'b0);
        rchk(12'h154, fc(14'h0aa0), 1'b0);
        `CHK("sel", 1'b1, sel)
        xfer(12'h1c0, 1'b1, 32'h0);
        // Skipped cell and stack, bipolar only sum
        sc.cell_measured <= 1'b0;
        sc.cell_measure_enable <= 1'b0;
        sc.stack_measured <= 1'b0;
        sc.stack_measure_enable <= 1'b0;
        sc.last_cell_code <= 14'h0001;
        sc.stack_voltage_code <= 14'h0002;
        sc.diagnostic_code_first <= 14'h2000;
        sc.diagnostic_code_second <= 14'h0003;
        cc <= {14{14'h3c00}};
        en <= 14'h0003;
        bip <= 14'h3fff;
        pulse();
        rchk(12'h150, fc(14'h3fff), 1'b0);
        rchk(12'h154, fc(14'h2abc), 1'b0);
        rchk(12'h158, 32'h0, 1'b0);
        rchk(12'h15c, fc(14'h2000), 1'b0);
        rchk(12'h160, fc(14'h0003), 1'b0);
        // Mixed encodings, twelve large disabled channels left out
        cc <= {{12{14'h3fff}}, 14'h3c00, 14'h1000};
        bip <= 14'h0002;
        sc.cell_measured <= 1'b1;
        sc.last_cell_code <= 14'h0abc;
        pulse();
        rchk(12'h158, 32'h00000300, 1'b0);
        rchk(12'h150, fc(14'h0abc), 1'b0);
        rchk(12'h154, fc(14'h2abc), 1'b0);
        // Unaligned and unmapped, then the status word
        rchk(12'h151, 32'h0, 1'b1);
        rchk(12'h200, 32'h0, 1'b1);
        rchk(12'h1c4, 32'h0003c31f, 1'b0);
        idle();
        finish_test();
    end
endmodule : mrr_regs_tb_top
`default_nettype wire
